// ### hdl/fsp_pkg.sv
// constants and types for the flash self-programming sequencer
package fsp_pkg;
   // register byte offsets on the bus
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   // control register bit positions
   localparam int STORE_EN_POS = 0;
   localparam int PAGE_ERASE_POS = 1;
   localparam int PAGE_WRITE_POS = 2;
   localparam int READ_FUSE_POS = 3;
   localparam int CLEAR_BUF_POS = 4;
   localparam int READ_SIG_POS = 5;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
   // accepted command patterns
   localparam logic [CTRL_W-1:0] CMD_LOAD = 6'h01;
   localparam logic [CTRL_W-1:0] CMD_ERASE = 6'h03;
   localparam logic [CTRL_W-1:0] CMD_WRITE = 6'h05;
   localparam logic [CTRL_W-1:0] CMD_RD_FUSE = 6'h09;
   localparam logic [CTRL_W-1:0] CMD_CLR_BUF = 6'h11;
   localparam logic [CTRL_W-1:0] CMD_RD_SIG = 6'h21;
   // command windows in system clock cycles
   localparam logic [2:0] STORE_WIN = 3'h4;
   localparam logic [2:0] LOAD_WIN = 3'h3;
   // z addresses in fuse/lock read mode
   localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
   // value of an erased buffer word and of an unmapped byte
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [7:0] BLANK_BYTE = 8'hff;
   // status register bits
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_LOADED_POS = 1;
   localparam int STAT_FUSE_POS = 2;
   localparam int STAT_EEP_POS = 3;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {st_idle, st_erase, st_write} fsp_state_e;
endpackage : fsp_pkg

// ### hdl/fsp_ctrl.sv
// flash self-programming sequencer with ahb-lite control registers
// How it works
// - store inert unless self-programming fuse programmed
// - page buffer words load in any order
// - pattern 00000011 then store erases page
// - erase ignores z bits outside page field
// - cpu halted through whole page erase
// - pattern 00000001 then store loads buffer word
// - buffer cleared after write, clear bit, reset
// - eeprom write during loading discards buffer
// - pattern 00000101 then store writes page
// - cpu halted through whole page write
// - z low bits word, high bits page
// - load instruction picks byte with z0
// - eeprom write blocks programming and fuse reads
// - programmed fuse bits read zero, others one
// - z 0x0001 in fuse mode returns lock bits
// - read and enable bits auto-clear, then normal
// - z 0,3,2 return fuse low, high, extended
// - signature mode returns table entry at z
// - control bits clear4 fuse3 write2 erase1 enable0
// - other control patterns are ignored
// - enable bit stays high until operation ends
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fsp_ctrl #(
   parameter int WORD_BITS = 5,
   parameter int SIG_BYTES = 3,
   // arbitrary neutral signature contents, not a real part code
   parameter logic [8*SIG_BYTES-1:0] SIG_TABLE = 24'h5a_a5_01
) (
   input wire logic core_clk,
   input wire logic arst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // cpu instruction side
   input wire logic store_program_instr,
   input wire logic lpm_strobe,
   input wire logic [15:0] z_ptr,
   input wire logic [15:0] r1r0_data,
   output logic cpu_halt,
   output logic [7:0] lpm_data,
   output logic lpm_valid,
   // flash array side
   output logic [14:0] flash_rd_addr,
   input wire logic [15:0] flash_rd_word,
   output logic flash_erase_go,
   output logic flash_write_go,
   output logic [15-WORD_BITS-1:0] flash_page,
   input wire logic flash_done,
   input wire logic [WORD_BITS-1:0] buf_rd_idx,
   output logic [15:0] buf_rd_data,
   // fuses, lock bits and eeprom interlock
   input wire logic self_prog_fuse,
   input wire logic [7:0] fuse_low_byte,
   input wire logic [7:0] fuse_high_byte,
   input wire logic [7:0] fuse_extended_byte,
   input wire logic [7:0] lock_byte,
   input wire logic eeprom_write_pending
);
   localparam int PAGE_WORDS = 1 << WORD_BITS;
   localparam int PAGE_W = 15 - WORD_BITS;

   typedef struct packed {
      fsp_pkg::fsp_state_e st;
      logic [fsp_pkg::CTRL_W-1:0] ctrl;
      logic [2:0] win;
      logic [PAGE_W-1:0] page;
      logic [PAGE_WORDS-1:0][15:0] pbuf;
      logic [PAGE_WORDS-1:0] loaded;
      logic [15:0] buf_rd;
      logic [7:0] lpm_data;
      logic lpm_valid;
      logic erase_go;
      logic write_go;
      logic dp_wr;
      logic dp_rd;
      logic [3:0] dp_addr;
      logic [31:0] hrdata;
   } fsp_state_s;

   fsp_state_s s_reg;
   fsp_state_s s_next;

   logic addr_ok;
   logic ctrl_wr;
   logic cmd_ok;
   logic store_ok;
   logic load_mode;
   logic [WORD_BITS-1:0] z_word;
   logic [PAGE_W-1:0] z_page;
   logic [7:0] sig_byte;
   logic [7:0] fuse_byte;

   // z split into word and page fields
   assign z_word = z_ptr[WORD_BITS:1];
   assign z_page = z_ptr[15:WORD_BITS+1];
   // byte-wide load, z0 picks the byte
   assign flash_rd_addr = z_ptr[15:1];

   assign addr_ok = hsel && hready && (htrans == fsp_pkg::HTRANS_NONSEQ);
   assign ctrl_wr = s_reg.dp_wr && (s_reg.dp_addr == fsp_pkg::CTRL_OFS);

   // command codes fix the bit positions
   // only the documented patterns take effect
   always_comb begin
      case (hwdata[fsp_pkg::CTRL_W-1:0])
         fsp_pkg::CMD_LOAD, fsp_pkg::CMD_ERASE, fsp_pkg::CMD_WRITE,
         fsp_pkg::CMD_RD_FUSE, fsp_pkg::CMD_CLR_BUF, fsp_pkg::CMD_RD_SIG: cmd_ok = 1'b1;
         default: cmd_ok = 1'b0;
      endcase
   end

   // store only acts when the fuse reads programmed
   // eeprom write in flight blocks every store
   assign store_ok = store_program_instr && (s_reg.win != 3'h0) && !self_prog_fuse
      && !eeprom_write_pending && (s_reg.st == fsp_pkg::st_idle);

   // load window is the first three clocks of the four
   assign load_mode = lpm_strobe && (s_reg.win > (fsp_pkg::STORE_WIN - fsp_pkg::LOAD_WIN))
      && !eeprom_write_pending && (s_reg.st == fsp_pkg::st_idle);

   always_comb begin
      sig_byte = fsp_pkg::BLANK_BYTE;
      if (z_ptr < 16'(SIG_BYTES)) begin
         sig_byte = SIG_TABLE[8*z_ptr[7:0] +: 8];
      end
   end

   // fuse inputs already carry programmed bits as zero
   always_comb begin
      case (z_ptr)
         fsp_pkg::Z_FUSE_LOW: fuse_byte = fuse_low_byte;
         fsp_pkg::Z_LOCK: fuse_byte = lock_byte;
         fsp_pkg::Z_FUSE_EXT: fuse_byte = fuse_extended_byte;
         fsp_pkg::Z_FUSE_HIGH: fuse_byte = fuse_high_byte;
         default: fuse_byte = fsp_pkg::BLANK_BYTE;
      endcase
   end

   always_comb begin
      s_next = s_reg;
      s_next.erase_go = 1'b0;
      s_next.write_go = 1'b0;
      s_next.lpm_valid = 1'b0;
      s_next.buf_rd = s_reg.pbuf[buf_rd_idx];

      // bus address phase; the slave never inserts wait states
      s_next.dp_wr = addr_ok && hwrite;
      s_next.dp_rd = addr_ok && !hwrite;
      s_next.dp_addr = haddr[3:0];
      s_next.hrdata = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         if (haddr[3:0] == fsp_pkg::CTRL_OFS) begin
            s_next.hrdata[fsp_pkg::CTRL_W-1:0] = s_reg.ctrl;
         end else if (haddr[3:0] == fsp_pkg::STAT_OFS) begin
            s_next.hrdata[fsp_pkg::STAT_BUSY_POS] = (s_reg.st != fsp_pkg::st_idle);
            s_next.hrdata[fsp_pkg::STAT_LOADED_POS] = |s_reg.loaded;
            s_next.hrdata[fsp_pkg::STAT_FUSE_POS] = self_prog_fuse;
            s_next.hrdata[fsp_pkg::STAT_EEP_POS] = eeprom_write_pending;
         end
      end

      // window counts down one per clock
      if (s_reg.win != 3'h0) begin
         s_next.win = s_reg.win - 3'h1;
      end

      // expiry with no instruction drops the command bits
      if (s_reg.win == 3'h1 && s_reg.st == fsp_pkg::st_idle) begin
         s_next.ctrl = fsp_pkg::CTRL_RESET;
      end

      // normal load returns the byte picked by z0
      if (lpm_strobe) begin
         s_next.lpm_valid = 1'b1;
         s_next.lpm_data = z_ptr[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
      end

      // read modes clear on the load, then loads are normal
      if (load_mode && s_reg.ctrl == fsp_pkg::CMD_RD_FUSE) begin
         s_next.lpm_data = fuse_byte;
         s_next.ctrl = fsp_pkg::CTRL_RESET;
         s_next.win = 3'h0;
      end else if (load_mode && s_reg.ctrl == fsp_pkg::CMD_RD_SIG) begin
         s_next.lpm_data = sig_byte;
         s_next.ctrl = fsp_pkg::CTRL_RESET;
         s_next.win = 3'h0;
      end

      if (store_ok) begin
         s_next.win = 3'h0;
         s_next.ctrl = fsp_pkg::CTRL_RESET;
         case (s_reg.ctrl)
            // erase takes the page field only
            // word bits and r1r0 play no part
            fsp_pkg::CMD_ERASE: begin
               s_next.st = fsp_pkg::st_erase;
               s_next.page = z_page;
               s_next.erase_go = 1'b1;
               s_next.ctrl = s_reg.ctrl;
            end
            // write takes the page field, data from buffer
            fsp_pkg::CMD_WRITE: begin
               s_next.st = fsp_pkg::st_write;
               s_next.page = z_page;
               s_next.write_go = 1'b1;
               s_next.ctrl = s_reg.ctrl;
            end
            // r1r0 into the word selected by z
            // any word may be loaded, in any order, while no erase or write runs
            fsp_pkg::CMD_LOAD: begin
               s_next.pbuf[z_word] = r1r0_data;
               s_next.loaded[z_word] = 1'b1;
            end
            fsp_pkg::CMD_CLR_BUF: begin
               s_next.pbuf = {PAGE_WORDS{fsp_pkg::ERASED_WORD}};
               s_next.loaded = '0;
            end
            default: begin
               s_next.ctrl = fsp_pkg::CTRL_RESET;
            end
         endcase
      end

      // eeprom activity mid-load throws the buffer away
      if (eeprom_write_pending && (|s_reg.loaded)) begin
         s_next.pbuf = {PAGE_WORDS{fsp_pkg::ERASED_WORD}};
         s_next.loaded = '0;
      end

      // erase holds the cpu until the array reports done
      // enable bit held for the whole operation
      case (s_reg.st)
         fsp_pkg::st_erase: begin
            if (flash_done) begin
               s_next.st = fsp_pkg::st_idle;
               s_next.ctrl = fsp_pkg::CTRL_RESET;
            end
         end
         fsp_pkg::st_write: begin
            if (flash_done) begin
               s_next.st = fsp_pkg::st_idle;
               s_next.ctrl = fsp_pkg::CTRL_RESET;
               s_next.pbuf = {PAGE_WORDS{fsp_pkg::ERASED_WORD}};
               s_next.loaded = '0;
            end
         end
         default: begin
         end
      endcase

      // control writes ignored while eeprom busy or flash busy
      // a valid write opens a fresh window
      if (ctrl_wr && cmd_ok && !eeprom_write_pending && s_reg.st == fsp_pkg::st_idle) begin
         s_next.ctrl = hwdata[fsp_pkg::CTRL_W-1:0];
         s_next.win = fsp_pkg::STORE_WIN;
      end
   end

   // reset leaves the buffer erased and empty
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg.st <= fsp_pkg::st_idle;
         s_reg.ctrl <= fsp_pkg::CTRL_RESET;
         s_reg.win <= 3'h0;
         s_reg.page <= '0;
         s_reg.pbuf <= {PAGE_WORDS{fsp_pkg::ERASED_WORD}};
         s_reg.loaded <= '0;
         s_reg.buf_rd <= 16'h0000;
         s_reg.lpm_data <= 8'h00;
         s_reg.lpm_valid <= 1'b0;
         s_reg.erase_go <= 1'b0;
         s_reg.write_go <= 1'b0;
         s_reg.dp_wr <= 1'b0;
         s_reg.dp_rd <= 1'b0;
         s_reg.dp_addr <= 4'h0;
         s_reg.hrdata <= 32'h0000_0000;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = fsp_pkg::HRESP_OKAY;
   assign hrdata = s_reg.hrdata;
   assign cpu_halt = (s_reg.st != fsp_pkg::st_idle);
   assign lpm_data = s_reg.lpm_data;
   assign lpm_valid = s_reg.lpm_valid;
   assign flash_erase_go = s_reg.erase_go;
   assign flash_write_go = s_reg.write_go;
   assign flash_page = s_reg.page;
   assign buf_rd_data = s_reg.buf_rd;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   a_fuse_inert: assert property (
      (store_program_instr && self_prog_fuse)
      |=> !flash_erase_go && !flash_write_go && !$changed(s_reg.loaded))
      else $error("store acted with self-programming disabled");

   a_erase_start: assert property (
      (store_ok && s_reg.ctrl == fsp_pkg::CMD_ERASE)
      |=> flash_erase_go && cpu_halt && flash_page == $past(z_ptr[15:WORD_BITS+1]))
      else $error("erase command did not start on the right page");

   a_write_start: assert property (
      (store_ok && s_reg.ctrl == fsp_pkg::CMD_WRITE) |=> flash_write_go ##1 !flash_write_go)
      else $error("page write did not start as a single pulse");

   a_halt_hold: assert property (
      (cpu_halt && !flash_done) |=> cpu_halt && s_reg.ctrl[fsp_pkg::STORE_EN_POS])
      else $error("cpu or enable bit released before flash done");

   a_load_word: assert property (
      (store_ok && s_reg.ctrl == fsp_pkg::CMD_LOAD && !eeprom_write_pending)
      |=> s_reg.pbuf[$past(z_word)] == $past(r1r0_data) && s_reg.ctrl == fsp_pkg::CTRL_RESET)
      else $error("buffer word not loaded from r1r0");

   a_buf_clear: assert property (
      (s_reg.st == fsp_pkg::st_write && flash_done) |=> s_reg.loaded == '0 && !cpu_halt)
      else $error("buffer not cleared after page write");

   a_eep_discard: assert property (
      (eeprom_write_pending && (|s_reg.loaded)) |=> s_reg.loaded == '0)
      else $error("eeprom write did not discard buffer");

   a_window_end: assert property (
      (ctrl_wr && cmd_ok && !eeprom_write_pending && !cpu_halt)
      ##1 (!store_program_instr && !lpm_strobe && !ctrl_wr) [*4]
      |=> s_reg.ctrl == fsp_pkg::CTRL_RESET)
      else $error("command bits survived the four-cycle window");

   a_fuse_read: assert property (
      (load_mode && s_reg.ctrl == fsp_pkg::CMD_RD_FUSE && z_ptr == fsp_pkg::Z_FUSE_HIGH)
      |=> lpm_valid && lpm_data == $past(fuse_high_byte) && s_reg.ctrl == fsp_pkg::CTRL_RESET)
      else $error("fuse high byte not returned");

   a_bad_pattern: assert property (
      (ctrl_wr && !cmd_ok && s_reg.win == 3'h0 && !cpu_halt) |=> $stable(s_reg.ctrl))
      else $error("invalid control pattern took effect");

   a_eep_block: assert property (
      (store_program_instr && eeprom_write_pending) |=> !flash_erase_go && !flash_write_go)
      else $error("store acted while eeprom write pending");

   a_lock_read: assert property (
      (load_mode && s_reg.ctrl == fsp_pkg::CMD_RD_FUSE && z_ptr == fsp_pkg::Z_LOCK)
      |=> lpm_valid && lpm_data == $past(lock_byte))
      else $error("lock bits not returned");

   a_sig_read: assert property (
      (load_mode && s_reg.ctrl == fsp_pkg::CMD_RD_SIG && !(|z_ptr))
      |=> lpm_valid && lpm_data == SIG_TABLE[7:0] && s_reg.ctrl == fsp_pkg::CTRL_RESET)
      else $error("signature entry not returned");

   a_byte_pick: assert property (
      (lpm_strobe && !load_mode)
      |=> lpm_valid && lpm_data == ($past(z_ptr[0]) ? $past(flash_rd_word[15:8])
         : $past(flash_rd_word[7:0])))
      else $error("normal load returned the wrong byte");

   a_erase_hold: assert property (
      (s_reg.st == fsp_pkg::st_erase && !flash_done)
      |=> cpu_halt && flash_page == $past(flash_page))
      else $error("erase released the cpu or changed page early");

endmodule : fsp_ctrl

// ### tb/fsp_flash_model.sv
// flash array model: answers erase and write starts, sweeps the page buffer
`timescale 1ns/1ps
module fsp_flash_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic [14:0] flash_rd_addr,
   output logic [15:0] flash_rd_word,
   input wire logic flash_erase_go,
   input wire logic flash_write_go,
   input wire logic [9:0] flash_page,
   output logic flash_done,
   input wire logic [4:0] peek_idx,
   output logic [4:0] buf_rd_idx,
   input wire logic [15:0] buf_rd_data,
   output logic order_bad
);
   logic [15:0] last_wr [32];
   logic [9:0] er_page;
   logic er_ok, wr_run;
   int cnt, ecnt;
   assign flash_rd_word = {flash_rd_addr[7:0] ^ 8'h3c, flash_rd_addr[7:0]};
   // the sweep owns the buffer index during a write, the bench peeks otherwise
   assign buf_rd_idx = wr_run ? cnt[4:0] : peek_idx;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         {er_ok, wr_run, flash_done, order_bad} <= '0;
         er_page <= '0;
         cnt <= 0;
         ecnt <= 0;
      end else begin
         flash_done <= 1'b0;
         if (flash_erase_go) begin
            er_page <= flash_page;
            er_ok <= 1'b1;
            ecnt <= slow ? 40 : 2;
         end
         // a write must hit the page erased just before
         if (flash_write_go) begin
            order_bad <= order_bad | !er_ok | (er_page != flash_page);
            er_ok <= 1'b0;
            wr_run <= 1'b1;
            cnt <= 0;
         end
         if (ecnt != 0) ecnt <= ecnt - 1;
         if (ecnt == 1) flash_done <= 1'b1;
         if (wr_run) begin
            cnt <= cnt + 1;
            if (cnt > 0) last_wr[cnt-1] <= buf_rd_data;
            if (cnt == 32) begin
               wr_run <= 1'b0;
               flash_done <= 1'b1;
            end
         end
      end
   end
endmodule : fsp_flash_model

// ### tb/flash_self_programming_test.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module flash_self_programming_test;
   localparam logic [23:0] SIG = 24'h3c_96_e1; // arbitrary signature contents
   localparam logic [31:0] A_CTRL = {28'h0, fsp_pkg::CTRL_OFS};
   localparam logic [31:0] A_STAT = {28'h0, fsp_pkg::STAT_OFS};
   logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp, store_program_instr, lpm_strobe;
   logic cpu_halt, lpm_valid, erase_go, write_go, flash_done, fuse_dis, eep, slow, order_bad;
   logic [31:0] haddr, hwdata, hrdata, rdata, seed;
   logic [1:0] htrans;
   logic [15:0] z_ptr, r1r0_data, rd_word, buf_data;
   logic [7:0] lpm_data, f_lo, f_hi, f_ex, lock_b;
   logic [14:0] rd_addr;
   logic [9:0] page;
   logic [4:0] buf_idx, peek_idx;
   logic [15:0] exp_buf [32];
   logic [5:0] pats [8] = '{6'h01, 6'h03, 6'h05, 6'h09, 6'h11, 6'h21, 6'h07, 6'h13};
   int failures, n_checks, halt_n;
   fsp_ctrl #(.SIG_TABLE(SIG)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .store_program_instr(store_program_instr), .lpm_strobe(lpm_strobe), .z_ptr(z_ptr),
      .r1r0_data(r1r0_data), .cpu_halt(cpu_halt), .lpm_data(lpm_data), .lpm_valid(lpm_valid),
      .flash_rd_addr(rd_addr),
      .flash_rd_word(rd_word), .flash_erase_go(erase_go), .flash_write_go(write_go),
      .flash_page(page), .flash_done(flash_done), .buf_rd_idx(buf_idx), .buf_rd_data(buf_data),
      .self_prog_fuse(fuse_dis), .fuse_low_byte(f_lo), .fuse_high_byte(f_hi),
      .fuse_extended_byte(f_ex), .lock_byte(lock_b), .eeprom_write_pending(eep));
   fsp_flash_model u_flash (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
      .flash_rd_addr(rd_addr), .flash_rd_word(rd_word), .flash_erase_go(erase_go),
      .flash_write_go(write_go), .flash_page(page), .flash_done(flash_done),
      .peek_idx(peek_idx), .buf_rd_idx(buf_idx), .buf_rd_data(buf_data), .order_bad(order_bad));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] norm(input logic [15:0] z);
      return z[0] ? z[8:1] ^ 8'h3c : z[8:1];
   endfunction : norm
   function automatic logic [7:0] fuse_exp(input int i);
      return i == 0 ? f_lo : i == 1 ? lock_b : i == 2 ? f_ex : f_hi;
   endfunction : fuse_exp
   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= fsp_pkg::HTRANS_NONSEQ;
      for (int k = 0; k < 50 && hreadyout !== 1'b1 || k == 0; k++) @(posedge core_clk);
      htrans <= 2'h0;
      hwdata <= d;
      for (int k = 0; k < 50 && hreadyout !== 1'b1 || k == 0; k++) @(posedge core_clk);
      rdata = hrdata;
      if (hreadyout !== 1'b1) begin
         failures++;
         finish_test();
      end
   endtask : bus
   task automatic store_op(input logic [15:0] z, input logic [15:0] d);
      store_program_instr <= 1'b1;
      z_ptr <= z;
      r1r0_data <= d;
      @(posedge core_clk);
      store_program_instr <= 1'b0;
      @(posedge core_clk);
   endtask : store_op
   task automatic lpm(input logic [15:0] z, input logic [7:0] e);
      lpm_strobe <= 1'b1;
      z_ptr <= z;
      @(posedge core_clk);
      lpm_strobe <= 1'b0;
      @(posedge core_clk);
      check("lpm valid", 32'(lpm_valid), 32'h1);
      check("lpm data", 32'(lpm_data), 32'(e));
   endtask : lpm
   task automatic peek(input logic [4:0] i, input logic [15:0] e);
      peek_idx <= i;
      repeat (2) @(posedge core_clk);
      check("buffer word", 32'(buf_data), 32'(e));
   endtask : peek
   task automatic wait_idle();
      for (halt_n = 0; halt_n < 300 && cpu_halt !== 1'b0; halt_n++) @(posedge core_clk);
      if (cpu_halt !== 1'b0) begin
         failures++;
         finish_test();
      end
   endtask : wait_idle
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      logic [15:0] z;
      int ix;
      {arst_n, hsel, hwrite, store_program_instr, lpm_strobe, fuse_dis, eep, slow} = '0;
      {haddr, hwdata, htrans, z_ptr, r1r0_data, peek_idx} = '0;
      seed = 32'hccd8;
      {f_lo, f_hi, f_ex, lock_b} = rnd();
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      hsel <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, A_CTRL, 32'h0);
      check("ctrl reset", rdata, 32'(fsp_pkg::CTRL_RESET));
      peek(5'h07, fsp_pkg::ERASED_WORD);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, A_CTRL, 32'(pats[i]));
         bus(1'b0, A_CTRL, 32'h0);
         check("ctrl", rdata, 32'(i < 6 ? pats[i] : 6'h00));
         repeat (5) @(posedge core_clk);
      end
      slow <= 1'b1;
      z = 16'(rnd());
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_ERASE));
      store_op(z, 16'(rnd()));
      check("erase go", 32'(erase_go), 32'h1);
      check("erase page", 32'(page), 32'(z[15:6]));
      check("halt", 32'(cpu_halt), 32'h1);
      bus(1'b0, A_CTRL, 32'h0);
      check("enable held", 32'(rdata[fsp_pkg::STORE_EN_POS]), 32'h1);
      wait_idle();
      check("erase span", 32'(halt_n > 30), 32'h1);
      // every word once, in scrambled order
      for (int i = 0; i < 32; i++) begin
         ix = (i * 13 + 5) % 32;
         exp_buf[ix] = 16'(rnd());
         bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_LOAD));
         store_op({z[15:6], 5'(ix), 1'(rnd())}, exp_buf[ix]);
      end
      peek(5'h05, exp_buf[5]);
      bus(1'b0, A_STAT, 32'h0);
      check("loaded", 32'(rdata[fsp_pkg::STAT_LOADED_POS]), 32'h1);
      slow <= 1'b0;
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_WRITE));
      // erased page again, other z bits zero
      store_op({z[15:6], 6'h00}, 16'(rnd()));
      check("write go", 32'(write_go), 32'h1);
      wait_idle();
      check("write span", 32'(halt_n >= 32), 32'h1);
      check("order", 32'(order_bad), 32'h0);
      for (int i = 0; i < 32; i++) begin
         check("page data", 32'(u_flash.last_wr[i]), 32'(exp_buf[i]));
      end
      peek(5'h05, fsp_pkg::ERASED_WORD);
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_LOAD));
      store_op(16'h0004, 16'h1234);
      peek(5'h02, 16'h1234);
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_CLR_BUF));
      store_op(16'h0000, 16'h0000);
      peek(5'h02, fsp_pkg::ERASED_WORD);
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_LOAD));
      store_op(16'h0006, 16'h5678);
      eep <= 1'b1;
      // the discard lands one clock after the pending flag rises
      @(posedge core_clk);
      peek(5'h03, fsp_pkg::ERASED_WORD);
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_RD_FUSE));
      bus(1'b0, A_CTRL, 32'h0);
      check("ctrl blocked", rdata, 32'h0);
      lpm(16'h0003, norm(16'h0003));
      eep <= 1'b0;
      // software sees the pending flag clear first
      bus(1'b0, A_STAT, 32'h0);
      check("eep clear", 32'(rdata[fsp_pkg::STAT_EEP_POS]), 32'h0);
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_ERASE));
      eep <= 1'b1;
      store_op(16'h0040, 16'h0000);
      check("eep blocks store", 32'(erase_go), 32'h0);
      eep <= 1'b0;
      fuse_dis <= 1'b1;
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_ERASE));
      store_op(16'h0040, 16'h0000);
      check("disabled", 32'(erase_go), 32'h0);
      fuse_dis <= 1'b0;
      // last store that still falls in the window, then the first one past it
      for (int d = 3; d < 5; d++) begin
         bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_ERASE));
         repeat (d) @(posedge core_clk);
         store_op(16'h0080, 16'h0000);
         check("window", 32'(erase_go), 32'(d == 3));
         wait_idle();
      end
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_RD_FUSE));
         lpm(16'(i), fuse_exp(i));
         bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_RD_SIG));
         lpm(16'(i), i < 3 ? SIG[8*i+:8] : 8'hff);
      end
      bus(1'b0, A_CTRL, 32'h0);
      check("ctrl after read", rdata, 32'h0);
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_RD_FUSE));
      repeat (3) @(posedge core_clk);
      lpm(16'h0001, norm(16'h0001));
      z = 16'(rnd());
      lpm(z, norm(z));
      // a reset in mid-run empties the buffer
      bus(1'b1, A_CTRL, 32'(fsp_pkg::CMD_LOAD));
      store_op(16'h0008, 16'h4321);
      peek(5'h04, 16'h4321);
      arst_n <= 1'b0;
      @(posedge core_clk);
      arst_n <= 1'b1;
      peek(5'h04, fsp_pkg::ERASED_WORD);
      finish_test();
   end
endmodule : flash_self_programming_test
